// ==== rtl/afc_regs.vh ====
// register offsets, field positions, reset values and timing counts for the
// filter and interrupt control register group; definitions only
`ifndef AFC_REGS_VH
`define AFC_REGS_VH
`define AFC_ADDR_W        7
`define AFC_HPF_CTRL      7'h21
`define AFC_PAD_CTRL      7'h22
`define AFC_SCALE_CTRL    7'h23
`define AFC_WAKE_CTRL     7'h24
`define AFC_ZERO_STROBE   7'h25
`define AFC_REF_VALUE     7'h26
`define AFC_BOOT_BIT      7
`define AFC_HPM_HI        6
`define AFC_HPM_LO        5
`define AFC_FDS_BIT       4
`define AFC_FILTER_TO_IRQ_B_BIT     3
`define AFC_FILTER_TO_IRQ_A_BIT     2
`define AFC_HPCF_HI       1
`define AFC_HPCF_LO       0
`define AFC_IHL_BIT       7
`define AFC_PPOD_BIT      6
`define AFC_LATCH_IRQ_B_BIT      5
`define AFC_I2CFG_HI      4
`define AFC_I2CFG_LO      3
`define AFC_LATCH_IRQ_A_BIT      2
`define AFC_I1CFG_HI      1
`define AFC_I1CFG_LO      0
`define AFC_FS_HI         5
`define AFC_FS_LO         4
`define AFC_SELFTEST_POLARITY_BIT    3
`define AFC_ST_BIT        1
`define AFC_SIM_BIT       0
`define AFC_SCALE_MASK    8'h3B
`define AFC_WAKE_MASK     8'h03
`define AFC_RST_BYTE      8'h00
`define AFC_TRIM_WORDS    4
`define AFC_TRIM_AW       2
`define AFC_CLK_MHZ       250
`define AFC_TRIM_STEP_NS  40
`define AFC_TRIM_STEP_CYC ((`AFC_TRIM_STEP_NS * `AFC_CLK_MHZ + 999) / 1000)
`endif

// ==== rtl/afc_ctrl_regs.v ====
// filter, interrupt pad, scale and wake control registers of an accelerometer
// assumes a serial-port front end on clk_i giving 7-bit address and strobes,
// and nonvolatile trim reached by a one-cycle read port
// events, data ready and source-read strobes come from logic on clk_i, so
// none of them passes a synchroniser
`timescale 1ns/100ps
`include "afc_regs.vh"

module afc_ctrl_regs (
  input  wire                   clk_i,
  input  wire                   rstn_i,
  // register access from the serial front end
  input  wire [`AFC_ADDR_W-1:0] reg_addr_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  input  wire [7:0]             reg_wdata_i,
  output reg  [7:0]             reg_rdata_o,
  // interrupt source register reads, decoded by the front end
  input  wire                   irq_a_source_reg_rd_i,
  input  wire                   irq_b_source_reg_rd_i,
  // raw events from the interrupt generators and data path
  input  wire                   irq_a_event_i,
  input  wire                   irq_b_event_i,
  input  wire                   data_ready_i,
  // trim memory read port and calibration write port
  output reg  [`AFC_TRIM_AW-1:0] trim_addr_o,
  output reg                    trim_rd_o,
  input  wire [7:0]             trim_data_i,
  output reg                    trim_we_o,
  output reg  [`AFC_TRIM_AW-1:0] trim_wr_addr_o,
  output reg  [7:0]             trim_wdata_o,
  output wire                   boot_running_o,
  // filter control
  output wire [1:0]             filter_mode_sel_o,
  output wire                   filtered_out_sel_o,
  output wire                   filter_to_irq_b_o,
  output wire                   filter_to_irq_a_o,
  output wire [1:0]             cutoff_sel_o,
  output reg  [6:0]             filter_coefficient_o,
  output wire                   filter_use_reference_o,
  output wire [7:0]             reference_bits_o,
  output reg                    filter_zero_o,
  // scale, self-test, serial mode, wake
  output wire [1:0]             full_scale_sel_o,
  output wire                   selftest_on_o,
  output wire                   selftest_polarity_o,
  output wire                   spi_wire_mode_o,
  output wire [1:0]             wake_mode_sel_o,
  // latched interrupt state
  output reg                    irq_a_held_o,
  output reg                    irq_b_held_o,
  // interrupt pads
  output reg                    int_a_pad_o,
  output reg                    int_a_pad_oe_o,
  output reg                    int_b_pad_o,
  output reg                    int_b_pad_oe_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_WAIT = 3'b100;
  // integer forms are cut to the counter widths on purpose
  localparam integer STEP_CYC_I  = `AFC_TRIM_STEP_CYC;
  localparam integer LAST_WORD_I = `AFC_TRIM_WORDS - 1;
  localparam [7:0] STEP_CYC = STEP_CYC_I[7:0];
  localparam [`AFC_TRIM_AW-1:0] LAST_WORD = LAST_WORD_I[`AFC_TRIM_AW-1:0];

  reg [7:0]             hpf_ctrl_r;
  reg [7:0]             pad_ctrl_r;
  reg [7:0]             scale_ctrl_r;
  reg [7:0]             wake_ctrl_r;
  reg [7:0]             ref_r;
  reg [2:0]             state_r;
  reg [2:0]             state_nxt;
  reg [`AFC_TRIM_AW-1:0] word_r;
  reg [7:0]             wait_r;
  reg                   pwr_boot_r;
  reg                   irq_a_lvl_r;
  reg                   irq_b_lvl_r;

  wire wr_hpf   = reg_wr_i && (reg_addr_i == `AFC_HPF_CTRL);
  wire wr_pad   = reg_wr_i && (reg_addr_i == `AFC_PAD_CTRL);
  wire wr_scale = reg_wr_i && (reg_addr_i == `AFC_SCALE_CTRL);
  wire wr_wake  = reg_wr_i && (reg_addr_i == `AFC_WAKE_CTRL);
  wire wr_ref   = reg_wr_i && (reg_addr_i == `AFC_REF_VALUE);
  wire copy_done = (state_r == ST_WAIT) && (wait_r == 8'h00) && (word_r == LAST_WORD);

  assign boot_running_o      = hpf_ctrl_r[`AFC_BOOT_BIT];
  assign filter_mode_sel_o   = hpf_ctrl_r[`AFC_HPM_HI:`AFC_HPM_LO];
  assign filtered_out_sel_o  = hpf_ctrl_r[`AFC_FDS_BIT];
  assign filter_to_irq_b_o   = hpf_ctrl_r[`AFC_FILTER_TO_IRQ_B_BIT];
  assign filter_to_irq_a_o   = hpf_ctrl_r[`AFC_FILTER_TO_IRQ_A_BIT];
  assign cutoff_sel_o        = hpf_ctrl_r[`AFC_HPCF_HI:`AFC_HPCF_LO];
  assign reference_bits_o    = ref_r;
  // code 11 is undefined; treated as normal mode
  assign filter_use_reference_o = (filter_mode_sel_o == 2'h1) &&
    (filtered_out_sel_o || filter_to_irq_b_o || filter_to_irq_a_o);
  assign full_scale_sel_o    = scale_ctrl_r[`AFC_FS_HI:`AFC_FS_LO];
  assign selftest_on_o       = scale_ctrl_r[`AFC_ST_BIT];
  assign selftest_polarity_o = scale_ctrl_r[`AFC_SELFTEST_POLARITY_BIT];
  assign spi_wire_mode_o     = scale_ctrl_r[`AFC_SIM_BIT];
  assign wake_mode_sel_o     = wake_ctrl_r[1:0];

  // pad level from a two-bit selection, before polarity
  function pad_level;
    input [1:0] sel;
    input       own;
    input       both;
    input       drdy;
    input       boot;
    begin
      case (sel)
        2'h0:    pad_level = own;
        2'h1:    pad_level = both;
        2'h2:    pad_level = drdy;
        default: pad_level = boot;
      endcase
    end
  endfunction

  // control registers; boot flag set by software or power-up, cleared by copy
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      hpf_ctrl_r   <= `AFC_RST_BYTE;
      pad_ctrl_r   <= `AFC_RST_BYTE;
      scale_ctrl_r <= `AFC_RST_BYTE;
      wake_ctrl_r  <= `AFC_RST_BYTE;
      ref_r        <= `AFC_RST_BYTE;
      pwr_boot_r   <= 1'b1;
    end else begin
      // one-shot: starts the power-up copy with no bus traffic
      pwr_boot_r <= 1'b0;
      if (wr_hpf) begin
        hpf_ctrl_r[6:0] <= reg_wdata_i[6:0];
      end
      // software set wins over completion clear
      if ((wr_hpf && reg_wdata_i[`AFC_BOOT_BIT]) || pwr_boot_r) begin
        hpf_ctrl_r[`AFC_BOOT_BIT] <= 1'b1;
      end else if (copy_done) begin
        hpf_ctrl_r[`AFC_BOOT_BIT] <= 1'b0;
      end
      if (wr_pad) begin
        pad_ctrl_r <= reg_wdata_i;
      end
      if (wr_scale) begin
        scale_ctrl_r <= reg_wdata_i & `AFC_SCALE_MASK;
      end
      if (wr_wake) begin
        wake_ctrl_r <= reg_wdata_i & `AFC_WAKE_MASK;
      end
      if (wr_ref) begin
        ref_r <= reg_wdata_i;
      end
    end
  end

  // trim copy sequencer: read a word, wait, write it to calibration
  // each word costs one read cycle, STEP_CYC+1 wait cycles, then the write;
  // a reboot request in the completion cycle of a copy keeps the flag up and the copy runs again
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (hpf_ctrl_r[`AFC_BOOT_BIT]) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (wait_r == 8'h00) begin
          state_nxt = (word_r == LAST_WORD) ? ST_IDLE : ST_READ;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      state_r        <= ST_IDLE;
      word_r         <= {`AFC_TRIM_AW{1'b0}};
      wait_r         <= 8'h00;
      trim_addr_o    <= {`AFC_TRIM_AW{1'b0}};
      trim_rd_o      <= 1'b0;
      trim_we_o      <= 1'b0;
      trim_wr_addr_o <= {`AFC_TRIM_AW{1'b0}};
      trim_wdata_o   <= 8'h00;
    end else begin
      state_r   <= state_nxt;
      trim_rd_o <= 1'b0;
      trim_we_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          word_r <= {`AFC_TRIM_AW{1'b0}};
        end
        ST_READ: begin
          trim_addr_o <= word_r;
          trim_rd_o   <= 1'b1;
          wait_r      <= STEP_CYC;
        end
        ST_WAIT: begin
          if (wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
          end else begin
            trim_we_o      <= 1'b1;
            trim_wr_addr_o <= word_r;
            trim_wdata_o   <= trim_data_i;
            word_r         <= word_r + 1'b1;
          end
        end
        default: begin
          word_r <= {`AFC_TRIM_AW{1'b0}};
        end
      endcase
    end
  end

  // filter coefficient and zeroing strobe
  // coefficient lags the cutoff field by one cycle; the zeroing read is
  // ignored in reference mode, where the filter follows the stored reference
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      filter_coefficient_o <= 7'h08;
      filter_zero_o        <= 1'b0;
    end else begin
      filter_coefficient_o <= 7'h08 << cutoff_sel_o;
      filter_zero_o <= reg_rd_i && (reg_addr_i == `AFC_ZERO_STROBE)
                       && (filter_mode_sel_o != 2'h1);
    end
  end

  // interrupt requests: latched until source read, event wins over clear
  // with the latch bit clear the pad follows the raw event only
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_a_held_o <= 1'b0;
      irq_b_held_o <= 1'b0;
    end else begin
      if (irq_a_event_i && pad_ctrl_r[`AFC_LATCH_IRQ_A_BIT]) begin
        irq_a_held_o <= 1'b1;
      end else if (irq_a_source_reg_rd_i || !pad_ctrl_r[`AFC_LATCH_IRQ_A_BIT]) begin
        irq_a_held_o <= 1'b0;
      end
      if (irq_b_event_i && pad_ctrl_r[`AFC_LATCH_IRQ_B_BIT]) begin
        irq_b_held_o <= 1'b1;
      end else if (irq_b_source_reg_rd_i || !pad_ctrl_r[`AFC_LATCH_IRQ_B_BIT]) begin
        irq_b_held_o <= 1'b0;
      end
    end
  end

  always @* begin
    irq_a_lvl_r = irq_a_event_i || irq_a_held_o;
    irq_b_lvl_r = irq_b_event_i || irq_b_held_o;
  end

  // pad levels after selection and polarity, registered below
  wire pad_a_lvl = pad_level(pad_ctrl_r[`AFC_I1CFG_HI:`AFC_I1CFG_LO], irq_a_lvl_r,
                             irq_a_lvl_r | irq_b_lvl_r, data_ready_i,
                             boot_running_o)
                   ^ pad_ctrl_r[`AFC_IHL_BIT];
  wire pad_b_lvl = pad_level(pad_ctrl_r[`AFC_I2CFG_HI:`AFC_I2CFG_LO], irq_b_lvl_r,
                             irq_a_lvl_r | irq_b_lvl_r, data_ready_i,
                             boot_running_o)
                   ^ pad_ctrl_r[`AFC_IHL_BIT];

  // pads: open-drain drives only the low level
  // the high level of an open-drain pad is left to the board pull-up
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      int_a_pad_o    <= 1'b0;
      int_a_pad_oe_o <= 1'b1;
      int_b_pad_o    <= 1'b0;
      int_b_pad_oe_o <= 1'b1;
    end else begin
      int_a_pad_o    <= pad_ctrl_r[`AFC_PPOD_BIT] ? 1'b0 : pad_a_lvl;
      int_a_pad_oe_o <= !pad_ctrl_r[`AFC_PPOD_BIT] || !pad_a_lvl;
      int_b_pad_o    <= pad_ctrl_r[`AFC_PPOD_BIT] ? 1'b0 : pad_b_lvl;
      int_b_pad_oe_o <= !pad_ctrl_r[`AFC_PPOD_BIT] || !pad_b_lvl;
    end
  end

  // read data; strobe address and unmapped addresses read zero
  // the zeroing location is a dummy: its read only clears the filter
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `AFC_HPF_CTRL) begin
        reg_rdata_o <= hpf_ctrl_r;
      end else if (reg_addr_i == `AFC_PAD_CTRL) begin
        reg_rdata_o <= pad_ctrl_r;
      end else if (reg_addr_i == `AFC_SCALE_CTRL) begin
        reg_rdata_o <= scale_ctrl_r;
      end else if (reg_addr_i == `AFC_WAKE_CTRL) begin
        reg_rdata_o <= wake_ctrl_r;
      end else if (reg_addr_i == `AFC_REF_VALUE) begin
        reg_rdata_o <= ref_r;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

endmodule // afc_ctrl_regs

// ==== verif/afc_trim_model.sv ====
// trim memory model standing behind the calibration copy port
// assumes the block holds trim_rd_o for one cycle per word
`timescale 1ns/100ps
module afc_trim_model (
  input  wire       clk_i,
  input  wire [1:0] trim_addr_i,
  input  wire       trim_rd_i,
  output reg  [7:0] trim_data_o
);
  initial trim_data_o = 8'h00;
  // word value tells which address was read
  always @(posedge clk_i) begin
    if (trim_rd_i)
      trim_data_o <= {6'h30, trim_addr_i};
  end
endmodule // afc_trim_model

// ==== verif/afc_ctrl_regs_sva.sv ====
// concurrent checks on the filter and pad control register block
// assumes the block is built with its default widths
`timescale 1ns/100ps
`include "afc_regs.vh"
module afc_ctrl_regs_chk (
  input wire                   clk_i,
  input wire                   rstn_i,
  input wire [`AFC_ADDR_W-1:0] reg_addr_i,
  input wire                   reg_rd_i,
  input wire                   reg_wr_i,
  input wire [7:0]             reg_wdata_i,
  input wire [7:0]             reg_rdata_o,
  input wire [1:0]             cutoff_sel_o,
  input wire [6:0]             filter_coefficient_o,
  input wire [1:0]             filter_mode_sel_o,
  input wire                   filter_zero_o,
  input wire                   boot_running_o,
  input wire                   trim_we_o,
  input wire                   irq_a_event_i,
  input wire                   irq_a_source_reg_rd_i,
  input wire                   irq_a_held_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire rd_ref = reg_rd_i && reg_addr_i == `AFC_REF_VALUE;
  wire rd_out = reg_rd_i && (reg_addr_i < 7'h21 || reg_addr_i > 7'h26);
  property p_coef; 1'b1 |=> filter_coefficient_o == (7'h08 << $past(cutoff_sel_o)); endproperty
  a_coef: assert property (p_coef) else $error("coefficient off");
  property p_zero;
    reg_rd_i && reg_addr_i == `AFC_ZERO_STROBE && filter_mode_sel_o != 2'h1 |=> filter_zero_o;
  endproperty
  a_zero: assert property (p_zero) else $error("no filter zero pulse");
  property p_ref; reg_wr_i && reg_addr_i == `AFC_REF_VALUE ##1 rd_ref
    |=> reg_rdata_o == $past(reg_wdata_i, 2); endproperty
  a_ref: assert property (p_ref) else $error("reference readback wrong");
  property p_unmap; rd_out |=> reg_rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_wake; reg_rd_i && reg_addr_i == `AFC_WAKE_CTRL |=> reg_rdata_o[7:2] == 6'h00;
  endproperty
  a_wake: assert property (p_wake) else $error("wake unused bits set");
  property p_bootclr; $fell(boot_running_o) |-> trim_we_o; endproperty
  a_bootclr: assert property (p_bootclr) else $error("boot flag cleared early");
  property p_powerup; $rose(rstn_i) |-> ##[1:3] boot_running_o; endproperty
  a_powerup: assert property (p_powerup) else $error("no copy after reset");
  property p_trim; $rose(boot_running_o) |-> ##[1:20] trim_we_o; endproperty
  a_trim: assert property (p_trim) else $error("trim copy stalled");
  property p_clear;
    irq_a_held_o && irq_a_source_reg_rd_i && !irq_a_event_i |=> !irq_a_held_o;
  endproperty
  a_clear: assert property (p_clear) else $error("latched request not cleared");
  c_zero: cover property (filter_zero_o);
  c_boot: cover property ($fell(boot_running_o));
  c_held: cover property (irq_a_held_o);
endmodule // afc_ctrl_regs_chk
bind afc_ctrl_regs afc_ctrl_regs_chk chk_u (.clk_i, .rstn_i, .reg_addr_i, .reg_rd_i, .reg_wr_i,
  .reg_wdata_i, .reg_rdata_o, .cutoff_sel_o, .filter_coefficient_o, .filter_mode_sel_o,
  .filter_zero_o, .boot_running_o, .trim_we_o, .irq_a_event_i, .irq_a_source_reg_rd_i,
  .irq_a_held_o);

// ==== verif/afc_ctrl_regs_tb.sv ====
// self-checking bench for the filter and pad control register block
// assumes the trim model of afc_trim_model on the copy port
`timescale 1ns/100ps
`include "afc_regs.vh"
`define CHK(n,e,g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module afc_ctrl_regs_tb;
  reg        clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, data_ready_i = 0;
  reg        irq_a_source_reg_rd_i = 0, irq_b_source_reg_rd_i = 0;
  reg        irq_a_event_i = 0, irq_b_event_i = 0;
  reg  [6:0] reg_addr_i = 7'h00;
  reg  [7:0] reg_wdata_i = 8'h00;
  wire [7:0] reg_rdata_o, trim_data_i, trim_wdata_o, reference_bits_o;
  wire [1:0] trim_addr_o, trim_wr_addr_o, filter_mode_sel_o, cutoff_sel_o;
  wire [1:0] full_scale_sel_o, wake_mode_sel_o;
  wire [6:0] filter_coefficient_o;
  wire       trim_rd_o, trim_we_o, boot_running_o, filtered_out_sel_o, filter_to_irq_b_o;
  wire       filter_to_irq_a_o, filter_use_reference_o, filter_zero_o, selftest_on_o;
  wire       selftest_polarity_o, spi_wire_mode_o, irq_a_held_o, irq_b_held_o;
  wire       int_a_pad_o, int_a_pad_oe_o, int_b_pad_o, int_b_pad_oe_o;
  integer    num_errors = 0, samples_checked = 0, n_trim = 0, n_zero = 0, i, k;
  afc_ctrl_regs dut_u (.clk_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .irq_a_source_reg_rd_i, .irq_b_source_reg_rd_i, .irq_a_event_i,
    .irq_b_event_i, .data_ready_i, .trim_addr_o, .trim_rd_o, .trim_data_i, .trim_we_o,
    .trim_wr_addr_o, .trim_wdata_o, .boot_running_o, .filter_mode_sel_o, .filtered_out_sel_o,
    .filter_to_irq_b_o, .filter_to_irq_a_o, .cutoff_sel_o, .filter_coefficient_o,
    .filter_use_reference_o, .reference_bits_o, .filter_zero_o, .full_scale_sel_o,
    .selftest_on_o, .selftest_polarity_o, .spi_wire_mode_o, .wake_mode_sel_o, .irq_a_held_o,
    .irq_b_held_o, .int_a_pad_o, .int_a_pad_oe_o, .int_b_pad_o, .int_b_pad_oe_o);
  afc_trim_model trim_u (.clk_i(clk_i), .trim_addr_i(trim_addr_o), .trim_rd_i(trim_rd_o),
    .trim_data_o(trim_data_i));
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (trim_we_o) begin
      `CHK("trim_wdata", {6'h30, n_trim[1:0]}, trim_wdata_o)
      `CHK("trim_waddr", n_trim[1:0], trim_wr_addr_o)
      n_trim <= n_trim + 1;
    end
    if (filter_zero_o)
      n_zero <= n_zero + 1;
  end
  task cyc(input w, input r, input [6:0] a, input [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
  endtask
  task wr(input [6:0] a, input [7:0] d);
    cyc(1, 0, a, d);
    cyc(0, 0, a, d);
  endtask
  task rd(input [6:0] a, input [7:0] e);
    cyc(0, 1, a, 8'h00);
    cyc(0, 0, a, 8'h00);
    @(posedge clk_i);
    #1 `CHK("rdata", e, reg_rdata_o)
  endtask
  task wait_boot;
    #1;
    for (k = 0; k < 200 && boot_running_o !== 1'b0; k = k + 1) begin
      @(posedge clk_i);
      #1;
    end
    // let the word counter take the last write pulse
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // level is the pad signal before polarity and drive type are applied
  task pad(input [7:0] cfg, input l);
    reg v;
    wr(`AFC_PAD_CTRL, cfg);
    repeat (3) @(posedge clk_i);
    #1 v = l ^ cfg[7];
    `CHK("pad_a", cfg[6] ? 1'b0 : v, int_a_pad_o)
    `CHK("pad_a_oe", cfg[6] ? ~v : 1'b1, int_a_pad_oe_o)
  endtask
  task t_boot;
    repeat (3) @(posedge clk_i);
    #1 `CHK("boot_on", 1'b1, boot_running_o)
    wait_boot;
    `CHK("boot_off", 1'b0, boot_running_o)
    `CHK("trim_words", 4, n_trim)
    for (i = 0; i < 6; i = i + 1)
      rd(7'h21 + i[6:0], `AFC_RST_BYTE);
    wr(`AFC_HPF_CTRL, 8'h80);
    wait_boot;
    `CHK("reboot_words", 8, n_trim)
    $display("t_boot done");
  endtask
  task t_regs;
    cyc(1, 0, `AFC_REF_VALUE, 8'h5A);
    rd(`AFC_REF_VALUE, 8'h5A);
    `CHK("ref_bits", 8'h5A, reference_bits_o)
    wr(`AFC_SCALE_CTRL, 8'hFF);
    rd(`AFC_SCALE_CTRL, `AFC_SCALE_MASK);
    `CHK("fs", 2'h3, full_scale_sel_o)
    `CHK("st", 2'h3, {selftest_on_o, selftest_polarity_o})
    `CHK("sim", 1'b1, spi_wire_mode_o)
    wr(`AFC_SCALE_CTRL, 8'h10);
    rd(`AFC_SCALE_CTRL, 8'h10);
    `CHK("fs4", 2'h1, full_scale_sel_o)
    `CHK("st_off", 3'h0, {selftest_on_o, selftest_polarity_o, spi_wire_mode_o})
    wr(`AFC_WAKE_CTRL, 8'hFF);
    rd(`AFC_WAKE_CTRL, `AFC_WAKE_MASK);
    `CHK("wake", 2'h3, wake_mode_sel_o)
    wr(7'h27, 8'hFF);
    rd(7'h27, 8'h00);
    $display("t_regs done");
  endtask
  task t_filter;
    for (i = 0; i < 4; i = i + 1) begin
      wr(`AFC_HPF_CTRL, {6'h17, i[1:0]});
      rd(`AFC_HPF_CTRL, {6'h17, i[1:0]});
      `CHK("coef", 7'h08 << i, filter_coefficient_o)
    end
    `CHK("fds_en", 3'h7, {filtered_out_sel_o, filter_to_irq_b_o, filter_to_irq_a_o})
    `CHK("mode10_ref", 1'b0, filter_use_reference_o)
    wr(`AFC_HPF_CTRL, 8'h24);
    k = n_zero;
    rd(`AFC_ZERO_STROBE, 8'h00);
    `CHK("ref_mode", 3'h5, {filter_use_reference_o, filter_mode_sel_o})
    `CHK("no_zero", k, n_zero)
    wr(`AFC_HPF_CTRL, 8'h40);
    k = n_zero;
    rd(`AFC_ZERO_STROBE, 8'h00);
    `CHK("zero", k + 1, n_zero)
    `CHK("bypass", 3'h0, {filtered_out_sel_o, filter_to_irq_b_o, filter_to_irq_a_o})
    `CHK("bypass_ref", 1'b0, filter_use_reference_o)
    $display("t_filter done");
  endtask
  task t_pads;
    @(posedge clk_i) data_ready_i <= 1;
    pad(8'h02, 1);
    pad(8'h82, 1);
    pad(8'hC2, 1);
    pad(8'h42, 1);
    @(posedge clk_i) data_ready_i <= 0;
    pad(8'h02, 0);
    @(posedge clk_i) irq_b_event_i <= 1;
    pad(8'h01, 1);
    pad(8'h00, 0);
    @(posedge clk_i) irq_b_event_i <= 0;
    wr(`AFC_HPF_CTRL, 8'h80);
    pad(8'h03, 1);
    wait_boot;
    pad(8'h03, 0);
    $display("t_pads done");
  endtask
  task t_latch;
    wr(`AFC_PAD_CTRL, 8'h24);
    @(posedge clk_i) {irq_a_event_i, irq_b_event_i} <= 2'h3;
    @(posedge clk_i) {irq_a_event_i, irq_b_event_i} <= 2'h0;
    repeat (3) @(posedge clk_i);
    #1 `CHK("held", 3'h7, {irq_a_held_o, irq_b_held_o, int_a_pad_o})
    `CHK("held_b", 2'h3, {int_b_pad_o, int_b_pad_oe_o})
    @(posedge clk_i) {irq_a_source_reg_rd_i, irq_b_source_reg_rd_i} <= 2'h3;
    @(posedge clk_i) {irq_a_source_reg_rd_i, irq_b_source_reg_rd_i} <= 2'h0;
    repeat (2) @(posedge clk_i);
    #1 `CHK("cleared", 2'h0, {irq_a_held_o, irq_b_held_o})
    `CHK("cleared_b", 1'b0, int_b_pad_o)
    wr(`AFC_PAD_CTRL, 8'h00);
    @(posedge clk_i) irq_a_event_i <= 1;
    @(posedge clk_i) irq_a_event_i <= 0;
    repeat (3) @(posedge clk_i);
    #1 `CHK("unlatched", 1'b0, irq_a_held_o)
    $display("t_latch done");
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors = num_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1;
    t_boot;
    t_regs;
    t_filter;
    t_pads;
    t_latch;
    end_of_test;
  end
endmodule // afc_ctrl_regs_tb
